// ### adc_sweep_ctrl.sv
// Function
// - repeat mode reconverts one input while started
// - software trigger starts on start bit write
// - hardware trigger waits for selected source
// - source 00 starts on trigger pin fall
// - source 01 starts on timer B2 request
// - source 10 starts on timer A0 request
// - writing start bit 0 stops conversion
// - repeat without DMA raises no interrupt
// - sweep converts once, software trigger self-clears
// - sweep without DMA interrupts at sweep end
// - sweep group 2/4/6/8 inputs from index 0
// - repeat converts exactly one selected input
// - without DMA result goes to matching register
// - with DMA every result goes to register 0
// - with DMA only register 0 is updated
`timescale 1ns/1ps
`default_nettype none
module adc_sweep_ctrl #(
  parameter int RESULT_WIDTH = 10
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire adc_sweep_pkg::apb_req_type     apb_req_i,
  output logic [31:0]                         prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  input  wire logic                           external_trigger_input_i,
  input  wire logic                           timer_b2_req_i,
  input  wire logic                           timer_a0_req_i,
  output logic                                conv_start_o,
  output adc_sweep_pkg::conv_channel_type     conv_channel_o,
  input  wire logic                           conv_done_i,
  input  wire logic [RESULT_WIDTH-1:0]        conv_data_i,
  output logic                                conv_irq_o,
  output logic                                dma_req_o,
  output logic                                busy_o
);
  import adc_sweep_pkg::*;

  // result width must fit one bus word
  if (RESULT_WIDTH < 1 || RESULT_WIDTH > 32) begin : g_width_check
    $error("RESULT_WIDTH must be 1 to 32");
  end

  // control registers
  logic [4:0]              ctrl0_reg;     // channel, trigger select, start
  logic [4:0]              ctrl1_reg;     // sweep size, extension, mode
  logic [3:0]              ctrl2_reg;     // group, trigger source
  logic                    ctrl3_reg;     // dma mode enable
  logic                    flag_reg;      // interrupt request flag
  logic [RESULT_WIDTH-1:0] result_reg [8];
  logic                    pready_reg;
  seq_state_type           state_reg;
  seq_state_type           state_next;
  logic [2:0]              sweep_idx_reg;
  logic [2:0]              sweep_idx_next;
  logic                    start_next;    // issue a conversion
  logic                    irq_next;
  logic                    hw_clear;      // sweep end clears start bit under software trigger
  logic                    ext_fall;

  // field views
  wire [2:0] channel_select   = ctrl0_reg[CHANNEL_POS +: 3];
  wire       trigger_select   = ctrl0_reg[TRIGGER_SELECT_POS];
  wire       conversion_start = ctrl0_reg[CONVERSION_START_POS];
  wire [1:0] sweep_size       = ctrl1_reg[SWEEP_SIZE_POS +: 2];
  wire [1:0] input_extension  = ctrl1_reg[INPUT_EXTENSION_POS +: 2];
  wire       sweep_mode       = ctrl1_reg[SWEEP_MODE_POS];
  wire [1:0] input_group      = ctrl2_reg[INPUT_GROUP_POS +: 2];
  wire [1:0] trigger_source   = ctrl2_reg[TRIGGER_SOURCE_POS +: 2];
  wire       dma_mode_enable  = ctrl3_reg;

  // apb decode: one wait state so read data can come from a flop
  wire [7:0]  paddr    = apb_req_i.paddr;
  wire [31:0] pwdata   = apb_req_i.pwdata;
  wire        access   = psel_i & penable_i;
  wire        complete = access & pready_reg;
  wire        wr_en    = complete & apb_req_i.pwrite;
  wire        hit_c0   = (paddr == CTRL0_OFFSET);
  wire        hit_c1   = (paddr == CTRL1_OFFSET);
  wire        hit_c2   = (paddr == CTRL2_OFFSET);
  wire        hit_c3   = (paddr == CTRL3_OFFSET);
  wire        hit_flag = (paddr == FLAG_OFFSET);
  wire        hit_res  = (paddr >= RESULT_OFFSET) && (paddr <= RESULT_END)
                         && (paddr[1:0] == 2'b00);
  wire        mapped   = hit_c0 | hit_c1 | hit_c2 | hit_c3 | hit_flag
                         | hit_res;
  wire [2:0]  res_sel  = paddr[4:2];
  wire        wr_c0    = wr_en & hit_c0;
  wire        wr_start = wr_c0 & pwdata[CONVERSION_START_POS];
  wire        wr_stop  = wr_c0 & ~pwdata[CONVERSION_START_POS];
  wire        wr_flag  = wr_en & hit_flag;

  // read mux; other result registers stay readable under dma but stale
  wire [31:0] res_word = 32'(result_reg[res_sel]);
  wire [31:0] rd_word  =
    hit_c0   ? {27'h0, ctrl0_reg} :
    hit_c1   ? {27'h0, ctrl1_reg} :
    hit_c2   ? {28'h0, ctrl2_reg} :
    hit_c3   ? {31'h0, ctrl3_reg} :
    hit_flag ? {31'h0, flag_reg}  :
    hit_res  ? res_word           : 32'h0;

  // hardware trigger selection
  wire hw_trig = (trigger_source == TRIG_SRC_PIN)      ? ext_fall :
                 (trigger_source == TRIG_SRC_TIMER_B2) ? timer_b2_req_i :
                 (trigger_source == TRIG_SRC_TIMER_A0) ? timer_a0_req_i :
                 1'b0;

  // index being converted and where its result lands
  wire [2:0] last_idx  = {sweep_size, 1'b1};
  wire [2:0] cur_idx   = sweep_mode ? sweep_idx_reg : channel_select;
  wire [2:0] store_idx = dma_mode_enable ? 3'd0 : cur_idx;
  wire       conv_ok   = (state_reg == ST_CONVERT) & conv_done_i;
  wire       sweep_end = sweep_mode & (sweep_idx_reg == last_idx);

  // external trigger pin synchroniser and fall detector
  trigger_fall_detect u_trig (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (external_trigger_input_i),
    .fall_o (ext_fall)
  );

  // sequencer next state
  always_comb begin
    state_next     = state_reg;
    sweep_idx_next = sweep_idx_reg;
    start_next     = 1'b0;
    irq_next       = 1'b0;
    hw_clear       = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (wr_start) begin
          sweep_idx_next = 3'd0;
          if (pwdata[TRIGGER_SELECT_POS]) begin
            state_next = ST_WAIT_TRIG;
          end else begin
            state_next = ST_CONVERT;
            start_next = 1'b1;
          end
        end
      end
      ST_WAIT_TRIG: begin
        if (wr_stop) begin
          state_next = ST_IDLE;
        end else if (hw_trig) begin
          state_next = ST_CONVERT;
          start_next = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (wr_stop) begin
          state_next = ST_IDLE;
        end else if (conv_done_i) begin
          // dma mode wants an interrupt on every result
          irq_next = dma_mode_enable;
          if (!sweep_mode) begin
            start_next = 1'b1;
          end else if (sweep_end) begin
            state_next = ST_IDLE;
            hw_clear   = ~trigger_select;
            irq_next   = 1'b1;
          end else begin
            sweep_idx_next = sweep_idx_reg + 3'd1;
            start_next     = 1'b1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer and converter request flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg      <= ST_IDLE;
      sweep_idx_reg  <= 3'd0;
      conv_start_o   <= 1'b0;
      conv_irq_o     <= 1'b0;
      dma_req_o      <= 1'b0;
      busy_o         <= 1'b0;
      conv_channel_o <= '0;
    end else begin
      state_reg     <= state_next;
      sweep_idx_reg <= sweep_idx_next;
      conv_start_o  <= start_next;
      conv_irq_o    <= irq_next;
      dma_req_o     <= conv_ok & dma_mode_enable & ~wr_stop;
      busy_o        <= (state_next != ST_IDLE);
      if (start_next) begin
        conv_channel_o.group <= input_group;
        if (sweep_mode) begin
          conv_channel_o.extra <= 2'b00;
          conv_channel_o.index <= sweep_idx_next;
        end else begin
          conv_channel_o.extra <= input_extension;
          conv_channel_o.index <= channel_select;
        end
      end
    end
  end

  // control registers; a program write of start wins over hardware clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0_reg <= CTRL0_RESET;
      ctrl1_reg <= CTRL1_RESET;
      ctrl2_reg <= CTRL2_RESET;
      ctrl3_reg <= CTRL3_RESET;
    end else begin
      if (wr_c0) begin
        ctrl0_reg <= pwdata[4:0];
      end else if (hw_clear) begin
        ctrl0_reg[CONVERSION_START_POS] <= 1'b0;
      end
      if (wr_en & hit_c1) begin
        ctrl1_reg <= pwdata[4:0];
      end
      if (wr_en & hit_c2) begin
        ctrl2_reg <= pwdata[3:0];
      end
      if (wr_en & hit_c3) begin
        ctrl3_reg <= pwdata[DMA_MODE_ENABLE_POS];
      end
    end
  end

  // interrupt flag: a new request wins over a program clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= FLAG_RESET;
    end else if (irq_next & ~wr_stop) begin
      flag_reg <= 1'b1;
    end else if (wr_flag & ~pwdata[FLAG_POS]) begin
      flag_reg <= 1'b0;
    end
  end

  // result storage; results after a stop are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        result_reg[i] <= '0;
      end
    end else if (conv_ok & ~wr_stop) begin
      result_reg[store_idx] <= conv_data_i;
    end
  end

  // apb answer flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_reg <= 1'b0;
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
      prdata_o   <= 32'h0;
    end else begin
      pready_reg <= access & ~pready_reg;
      pready_o   <= access & ~pready_reg;
      pslverr_o  <= access & ~pready_reg & ~mapped;
      prdata_o   <= (access & ~pready_reg) ? rd_word : 32'h0;
    end
  end

  // ---- assertions ----
  property p_sw_start;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_IDLE && wr_start && !pwdata[TRIGGER_SELECT_POS])
      |=> conv_start_o && state_reg == ST_CONVERT;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software start did not issue a conversion");

  property p_hw_wait;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_WAIT_TRIG && !hw_trig && !wr_stop) |=> !conv_start_o;
  endproperty
  a_hw_wait: assert property (p_hw_wait)
    else $error("conversion began without a hardware trigger");

  property p_pin_trig;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_WAIT_TRIG && trigger_source == TRIG_SRC_PIN
      && ext_fall && !wr_stop) |=> conv_start_o;
  endproperty
  a_pin_trig: assert property (p_pin_trig)
    else $error("pin fall did not start conversion");

  property p_b2_trig;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_WAIT_TRIG && trigger_source == TRIG_SRC_TIMER_B2
      && timer_b2_req_i && !wr_stop) |=> conv_start_o;
  endproperty
  a_b2_trig: assert property (p_b2_trig)
    else $error("timer B2 request did not start conversion");

  property p_a0_trig;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_WAIT_TRIG && trigger_source == TRIG_SRC_TIMER_A0
      && timer_a0_req_i && !wr_stop) |=> conv_start_o;
  endproperty
  a_a0_trig: assert property (p_a0_trig)
    else $error("timer A0 request did not start conversion");

  property p_stop;
    @(posedge clk_i) disable iff (rst_i)
    wr_stop |=> state_reg == ST_IDLE && !conv_start_o ##1 !conv_start_o [*2];
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop write did not halt the sequencer");

  property p_repeat;
    @(posedge clk_i) disable iff (rst_i)
    (conv_ok && !sweep_mode && !wr_stop)
      |=> conv_start_o && conv_channel_o.index == $past(channel_select);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat mode did not restart conversion");

  property p_no_irq;
    @(posedge clk_i) disable iff (rst_i)
    conv_irq_o |-> $past(dma_mode_enable) || $past(sweep_end);
  endproperty
  a_no_irq: assert property (p_no_irq)
    else $error("unexpected interrupt request");

  property p_sweep_end;
    @(posedge clk_i) disable iff (rst_i)
    (conv_ok && sweep_end && !trigger_select && !wr_c0)
      |=> !conversion_start && conv_irq_o && flag_reg;
  endproperty
  a_sweep_end: assert property (p_sweep_end)
    else $error("sweep end handling wrong");

  property p_dma_store;
    @(posedge clk_i) disable iff (rst_i)
    (conv_ok && dma_mode_enable && !wr_stop)
      |=> result_reg[0] == $past(conv_data_i) && dma_req_o && conv_irq_o;
  endproperty
  a_dma_store: assert property (p_dma_store)
    else $error("dma result not placed in register 0");

  property p_ready;
    @(posedge clk_i) disable iff (rst_i)
    (access && !pready_reg) |=> pready_o;
  endproperty
  a_ready: assert property (p_ready)
    else $error("apb access not answered");
endmodule
`default_nettype wire

// ### adc_sweep_pkg.sv
`default_nettype none
package adc_sweep_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] CTRL0_OFFSET     = 8'h00;
  localparam logic [7:0] CTRL1_OFFSET     = 8'h04;
  localparam logic [7:0] CTRL2_OFFSET     = 8'h08;
  localparam logic [7:0] CTRL3_OFFSET     = 8'h0c;
  localparam logic [7:0] FLAG_OFFSET      = 8'h10;
  localparam logic [7:0] RESULT_OFFSET    = 8'h20;
  localparam logic [7:0] RESULT_END       = 8'h3c;
  // converter_control_0 fields
  localparam int CHANNEL_POS              = 0;
  localparam int TRIGGER_SELECT_POS       = 3;
  localparam int CONVERSION_START_POS     = 4;
  // converter_control_1 fields
  localparam int SWEEP_SIZE_POS           = 0;
  localparam int INPUT_EXTENSION_POS      = 2;
  localparam int SWEEP_MODE_POS           = 4;
  // converter_control_2 fields
  localparam int INPUT_GROUP_POS          = 0;
  localparam int TRIGGER_SOURCE_POS       = 2;
  // converter_control_3 and flag fields
  localparam int DMA_MODE_ENABLE_POS      = 0;
  localparam int FLAG_POS                 = 0;
  // reset values
  localparam logic [4:0] CTRL0_RESET      = 5'h00;
  localparam logic [4:0] CTRL1_RESET      = 5'h00;
  localparam logic [3:0] CTRL2_RESET      = 4'h0;
  localparam logic       CTRL3_RESET      = 1'b0;
  localparam logic       FLAG_RESET       = 1'b0;
  // hardware trigger source codes
  localparam logic [1:0] TRIG_SRC_PIN     = 2'b00;
  localparam logic [1:0] TRIG_SRC_TIMER_B2 = 2'b01;
  localparam logic [1:0] TRIG_SRC_TIMER_A0 = 2'b10;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_WAIT_TRIG = 2'b01,
    ST_CONVERT   = 2'b10
  } seq_state_type;

  // apb request fields that travel together
  typedef struct packed {
    logic [7:0]  paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  // analog input selection sent to the converter
  typedef struct packed {
    logic [1:0] extra;  // 01 extra input 0, 10 extra input 1
    logic [1:0] group;
    logic [2:0] index;
  } conv_channel_type;
endpackage
`default_nettype wire

// ### trigger_fall_detect.sv
`timescale 1ns/1ps
`default_nettype none
module trigger_fall_detect (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      fall_o
);
  logic sync1_reg;   // first stage, read only by the second
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;   // accepted pin level
  wire  agree = (sync2_reg == sync3_reg);

  // three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      level_reg <= 1'b1;
      fall_o    <= 1'b0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (agree) begin
        level_reg <= sync2_reg;
      end
      fall_o <= agree & level_reg & ~sync2_reg;
    end
  end
endmodule
`default_nettype wire

// ### adc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model #(
  parameter int RESULT_WIDTH = 10
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          start_i,
  input  wire adc_sweep_pkg::conv_channel_type channel_i,
  input  wire logic [2:0]                    delay_i,
  output logic                               done_o,
  output logic [RESULT_WIDTH-1:0]            data_o
);
  import adc_sweep_pkg::*;
  logic [3:0]              left_reg;   // cycles until the result is ready
  logic [RESULT_WIDTH-1:0] value_reg;  // result tied to the channel sampled

  // one done per start; data toggles when not valid, so stale data shows
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      left_reg <= 4'h0;
      data_o   <= '0;
    end else if (start_i) begin
      left_reg  <= {1'b0, delay_i} + 4'h1;
      value_reg <= RESULT_WIDTH'({channel_i, 3'b101});
    end else if (left_reg == 4'h1) begin
      done_o   <= 1'b1;
      data_o   <= value_reg;
      left_reg <= 4'h0;
    end else begin
      if (left_reg != 4'h0) left_reg <= left_reg - 4'h1;
      data_o <= ~data_o;
    end
  end
endmodule
`default_nettype wire

// ### adc_repeat_and_sweep_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_repeat_and_sweep_control_bench;
  import adc_sweep_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  apb_req_type      req = '0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             pin = 1'b1;    // trigger pin idles high
  logic             tb2 = 1'b0;
  logic             ta0 = 1'b0;
  logic             cstart;
  conv_channel_type cch;
  logic             cdone;
  logic [9:0]       cdata;
  logic             irq;
  logic             dreq;
  logic             busy;
  logic [2:0]       dly = 3'h0;    // random converter latency
  logic [31:0]      seed = 32'ha01beadb;
  logic [31:0]      rdat;
  logic             rerr;
  int               fail_count = 0;
  int               compares = 0;
  int               n_start = 0;
  int               n_irq = 0;
  int               n_dma = 0;
  conv_channel_type notes[$];      // expected channel of each start

  always #2.5 clk_i = ~clk_i;

  adc_sweep_ctrl #(.RESULT_WIDTH(10)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .apb_req_i(req), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .external_trigger_input_i(pin),
    .timer_b2_req_i(tb2), .timer_a0_req_i(ta0), .conv_start_o(cstart),
    .conv_channel_o(cch), .conv_done_i(cdone), .conv_data_i(cdata),
    .conv_irq_o(irq), .dma_req_o(dreq), .busy_o(busy));

  adc_conv_model #(.RESULT_WIDTH(10)) conv (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(cstart), .channel_i(cch),
    .delay_i(dly), .done_o(cdone), .data_o(cdata));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // result as the converter model forms it for group g, index i
  function automatic logic [31:0] res(input logic [1:0] g,
                                      input logic [2:0] i);
    return {22'h0, 2'b00, g, i, 3'b101};
  endfunction

  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout_hit();
    fail_count++;
    $display("Error at %0t: wait ran out", $time);
    close_out();
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int i;
    @(posedge clk_i);
    psel <= 1'b1;
    req  <= '{paddr: a, pwrite: w, pwdata: d};
    @(posedge clk_i);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    if (i == 20) timeout_hit();
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic note(input logic [1:0] g, input int i);
    notes.push_back('{extra: 2'b00, group: g, index: 3'(i)});
  endtask

  // let the sequencer start, then wait for it to go idle
  task automatic wait_idle();
    int i;
    repeat (3) @(posedge clk_i);
    for (i = 0; i < 500; i++) begin
      @(posedge clk_i);
      if (busy === 1'b0) break;
    end
    if (i == 500) timeout_hit();
    repeat (2) @(posedge clk_i);
  endtask

  // w: 0 pin fall, 1 timer b2, 2 timer a0; the pin is left low
  task automatic pulse(input int w);
    @(posedge clk_i);
    if (w == 0) pin <= 1'b0;
    else if (w == 1) tb2 <= 1'b1;
    else ta0 <= 1'b1;
    @(posedge clk_i);
    tb2 <= 1'b0;
    ta0 <= 1'b0;
  endtask

  // random converter latency, fresh every cycle
  always @(posedge clk_i) begin
    seed = xorshift(seed);
    dly <= seed[2:0];
  end

  // watcher: each start is matched against the oldest note
  always @(posedge clk_i) begin
    if (!rst_i && cstart === 1'b1) begin
      n_start++;
      if (notes.size() == 0) begin
        fail_count++;
        $display("Error at %0t: unexpected conversion start", $time);
      end else chk(32'(cch), 32'(notes.pop_front()));
    end
    if (irq === 1'b1) n_irq++;
    if (dreq === 1'b1) n_dma++;
  end

  initial begin
    logic [2:0] ch;
    logic [1:0] g;
    logic [1:0] e;
    int         k;
    int         irq0;
    int         dma0;
    int         j;
    int         src;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTRL0_OFFSET, 32'h0);
    apb(8'h14, 1'b0, 32'h0);
    chk(32'(rerr), 32'h1);
    $display("test reset and unmapped done");
    // repeat mode on a random input, stopped by software
    ch = seed[2:0];
    g  = seed[4:3];
    e  = seed[6:5];
    wr(CTRL1_OFFSET, 32'(e) << INPUT_EXTENSION_POS);
    wr(CTRL2_OFFSET, 32'(g));
    for (j = 0; j < 12; j++) begin
      notes.push_back('{extra: e, group: g, index: ch});
    end
    irq0 = n_irq;
    k    = n_start;
    wr(CTRL0_OFFSET, 32'h10 | 32'(ch));
    for (j = 0; j < 500; j++) begin
      @(posedge clk_i);
      if (n_start >= k + 3) break;
    end
    if (j == 500) timeout_hit();
    wr(CTRL0_OFFSET, 32'(ch));
    wait_idle();
    k = n_start;
    repeat (20) @(posedge clk_i);
    chk(32'(n_start), 32'(k));
    chk(32'(n_irq), 32'(irq0));
    rd(RESULT_OFFSET + 8'(4 * ch), res(g, ch) | (32'(e) << 8));
    notes.delete();
    $display("test repeat done");
    // single sweep of every size, one group each
    for (k = 0; k < 4; k++) begin
      wr(CTRL1_OFFSET, 32'h10 | 32'(k));
      wr(CTRL2_OFFSET, 32'(k));
      for (j = 0; j < 2 * k + 2; j++) note(2'(k), j);
      irq0 = n_irq;
      wr(CTRL0_OFFSET, 32'h10);
      wait_idle();
      chk(32'(notes.size()), 32'h0);
      chk(32'(n_irq), 32'(irq0 + 1));
      rd(CTRL0_OFFSET, 32'h0);
      for (j = 0; j < 2 * k + 2; j++) begin
        rd(RESULT_OFFSET + 8'(4 * j), res(2'(k), 3'(j)));
      end
    end
    $display("test single sweep done");
    // dma mode: every result in register 0, one request each
    wr(FLAG_OFFSET, 32'h0);
    wr(CTRL3_OFFSET, 32'h1);
    wr(CTRL1_OFFSET, 32'h11);
    wr(CTRL2_OFFSET, 32'h3);
    for (j = 0; j < 4; j++) note(2'h3, j);
    irq0 = n_irq;
    dma0 = n_dma;
    wr(CTRL0_OFFSET, 32'h10);
    wait_idle();
    chk(32'(n_irq), 32'(irq0 + 4));
    chk(32'(n_dma), 32'(dma0 + 4));
    rd(RESULT_OFFSET, res(2'h3, 3'h3));
    rd(FLAG_OFFSET, 32'h1);
    wr(FLAG_OFFSET, 32'h0);
    rd(FLAG_OFFSET, 32'h0);
    wr(CTRL3_OFFSET, 32'h0);
    $display("test dma done");
    // hardware triggers: the wrong source is ignored, the right one runs
    wr(CTRL1_OFFSET, 32'h10);
    for (src = 0; src < 3; src++) begin
      wr(CTRL2_OFFSET, 32'(src) << 2);
      note(2'h0, 0);
      note(2'h0, 1);
      k = n_start;
      wr(CTRL0_OFFSET, 32'h18);
      pulse((src == 1) ? 2 : 1);
      repeat (10) @(posedge clk_i);
      chk(32'(n_start), 32'(k));
      pulse(src);
      wait_idle();
      chk(32'(notes.size()), 32'h0);
      pin <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
    $display("test hardware triggers done");
    close_out();
  end
endmodule
`default_nettype wire
